// *** core/udbc_counter.sv ***
// Four-bit up/down counter, decade or binary, with APB status view.
// Assumes all counter controls are driven by logic on clock;
// async_clear_n may arrive at any time.
`timescale 1ns/1ps

// Summary of operation
// - Decade mode wraps nine to zero, zero to nine
// - Binary mode wraps fifteen to zero and back
// - State changes only on rising clock edge, except async clear
// - Priority: async clear, sync clear, load, count, hold
// - Async clear forces zero at once
// - Sync clear loads zero at next edge
// - Preset enable loads preset value at edge
// - Count only when both enables low
// - Direction high counts up, low down
// - Terminal count low at limit with trickle low
// - Terminal count decoded combinationally from state
// - Carry low in clock-low phase at limit when enabled
// - Output enable low drives count outputs
// - Output enable high only drops the data enable; count outputs stay driven, counting continues
module udbc_counter (
  input  wire logic        clock,                    // Counter clock
  input  wire logic        rst,                      // Sync reset
  input  wire logic        psel,                     // APB select
  input  wire logic        penable,                  // APB enable
  input  wire logic        pwrite,                   // APB write
  input  wire logic [7:0]  paddr,                    // APB byte address
  input  wire logic [31:0] pwdata,                   // APB write data
  output logic      [31:0] prdata,                   // APB read data
  output logic             pready,                   // APB ready
  output logic             pslverr,                  // APB error
  input  wire logic        async_clear_n,            // Master clear
  input  wire logic        sync_clear_n,             // Clear at edge
  input  wire logic        preset_enable_n,          // Load preset
  input  wire logic        count_enable_parallel_n,  // Count enable
  input  wire logic        count_enable_trickle_n,   // Count enable
  input  wire logic        count_up,                 // 1 up, 0 down
  input  wire logic        output_enable_n,          // Drive outputs
  input  wire logic [3:0]  preset_value_in,          // Preset data
  output logic      [3:0]  count_value_out,          // Count data
  output logic             count_value_oe,           // Data enable
  output logic             terminal_count_n,         // Limit decode
  output logic             gated_carry_n,            // Clocked carry
  output logic             irq                       // Interrupt
);

  logic [3:0]  count_reg;
  logic [3:0]  count_next;
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic [3:0]  mask_reg;
  logic [3:0]  mask_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic [3:0]  step_val;
  logic        at_limit;
  logic        decade;
  logic        count_en;
  logic        carry_cond;
  logic        addr_hit;
  logic        setup_rd;
  logic        acc_wr;
  logic        acc_rd;
  logic [3:0]  evt_set;
  logic [3:0]  evt_clr;
  logic [3:0]  status;
  udbc_pkg::udbc_mode_t mode;

  assign decade = ctrl_reg[udbc_pkg::CTRL_DECADE_BIT];

  udbc_step u_step (
    .state    (count_reg),
    .decade   (decade),
    .up       (count_up),
    .next_val (step_val),
    .at_limit (at_limit)
  );

  // Counter mode and next state

  always_comb begin
    count_en = !count_enable_parallel_n && !count_enable_trickle_n;
    if (!sync_clear_n) begin
      mode = udbc_pkg::MODE_SCLR;
    end else if (!preset_enable_n) begin
      mode = udbc_pkg::MODE_LOAD;
    end else if (count_en) begin
      mode = udbc_pkg::MODE_COUNT;
    end else begin
      mode = udbc_pkg::MODE_HOLD;
    end
    unique case (mode)
      udbc_pkg::MODE_SCLR:  count_next = udbc_pkg::CNT_ZERO;
      udbc_pkg::MODE_LOAD:  count_next = preset_value_in;
      udbc_pkg::MODE_COUNT: count_next = step_val;
      udbc_pkg::MODE_HOLD:  count_next = count_reg;
    endcase
    if (rst) begin
      count_next = udbc_pkg::CNT_ZERO;
    end
  end

  // Master clear acts without the clock; all else waits for the edge
  always_ff @(posedge clock or negedge async_clear_n) begin
    if (!async_clear_n) begin
      count_reg <= udbc_pkg::CNT_ZERO;
    end else begin
      count_reg <= count_next;
    end
  end

  // Pin side outputs

  always_comb begin
    // Decoded straight from state; it can glitch, so carry exists
    terminal_count_n = !(at_limit && !count_enable_trickle_n);
    carry_cond = sync_clear_n && preset_enable_n && count_en
                 && at_limit && async_clear_n;
    // Low only while the clock is low, so it is safe as a clock
    gated_carry_n = !(carry_cond && !clock);
    count_value_out = count_reg;
    count_value_oe = !output_enable_n;
  end

  // Events for the status register

  always_comb begin
    evt_set = '0;
    evt_set[udbc_pkg::EVT_UPWRAP] = (mode == udbc_pkg::MODE_COUNT)
                                    && at_limit && count_up;
    evt_set[udbc_pkg::EVT_DNWRAP] = (mode == udbc_pkg::MODE_COUNT)
                                    && at_limit && !count_up;
    evt_set[udbc_pkg::EVT_LOAD] = (mode == udbc_pkg::MODE_LOAD);
    evt_set[udbc_pkg::EVT_SCLR] = (mode == udbc_pkg::MODE_SCLR);
    if (!async_clear_n) begin
      evt_set = '0;
    end
  end

  udbc_sticky #(
    .W (udbc_pkg::EVT_W)
  ) u_status (
    .clock (clock),
    .rst   (rst),
    .set   (evt_set),
    .clr   (evt_clr),
    .q     (status)
  );

  // APB slave: read data is captured in the setup cycle

  always_comb begin
    setup_rd = psel && !penable && !pwrite;
    acc_wr = psel && penable && pwrite;
    acc_rd = psel && penable && !pwrite;
    pready = psel && penable;
    addr_hit = (paddr == udbc_pkg::CTRL_OFS)
               || (paddr == udbc_pkg::STAT_OFS)
               || (paddr == udbc_pkg::MASK_OFS)
               || (paddr == udbc_pkg::CNT_OFS);
    pslverr = pready && !addr_hit;
    prdata = prdata_reg;
    irq = |(status & mask_reg);
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    prdata_next = prdata_reg;
    evt_clr = '0;
    if (setup_rd) begin
      prdata_next = '0;
      unique case (paddr)
        udbc_pkg::CTRL_OFS: prdata_next = ctrl_reg;
        udbc_pkg::STAT_OFS: prdata_next[3:0] = status;
        udbc_pkg::MASK_OFS: prdata_next[3:0] = mask_reg;
        udbc_pkg::CNT_OFS: begin
          prdata_next[3:0] = count_reg;
          prdata_next[udbc_pkg::CNT_LIMIT_BIT] = !terminal_count_n;
          prdata_next[udbc_pkg::CNT_DIR_BIT] = count_up;
          prdata_next[udbc_pkg::CNT_OE_BIT] = count_value_oe;
        end
        default: prdata_next = '0;
      endcase
    end
    // Only bits that were seen are cleared, so later events survive
    if (acc_rd && paddr == udbc_pkg::STAT_OFS) begin
      evt_clr = prdata_reg[3:0];
    end
    if (acc_wr && paddr == udbc_pkg::CTRL_OFS) begin
      ctrl_next = {31'h0000_0000, pwdata[udbc_pkg::CTRL_DECADE_BIT]};
    end
    if (acc_wr && paddr == udbc_pkg::MASK_OFS) begin
      mask_next = pwdata[3:0];
    end
    if (rst) begin
      ctrl_next = udbc_pkg::CTRL_RST;
      mask_next = udbc_pkg::MASK_RST;
      prdata_next = '0;
    end
  end

  always_ff @(posedge clock) begin
    ctrl_reg <= ctrl_next;
    mask_reg <= mask_next;
    prdata_reg <= prdata_next;
  end

  // Checks

  a_decade_wrap: assert property (
    @(posedge clock) disable iff (rst || !async_clear_n)
    (decade && mode == udbc_pkg::MODE_COUNT && count_up
     && count_reg == 4'h9) |=> (count_reg == 4'h0 || !async_clear_n)
  ) else $error("decade count did not wrap nine to zero");

  a_binary_wrap: assert property (
    @(posedge clock) disable iff (rst || !async_clear_n)
    (!decade && mode == udbc_pkg::MODE_COUNT && !count_up
     && count_reg == 4'h0) |=> (count_reg == 4'hf)
  ) else $error("binary count did not wrap zero to fifteen");

  a_async_clear: assert property (
    @(posedge clock) disable iff (rst)
    !async_clear_n |-> (count_reg == 4'h0 && count_value_out == 4'h0)
  ) else $error("count not zero under master clear");

  a_sync_clear: assert property (
    @(posedge clock) disable iff (rst || !async_clear_n)
    (!sync_clear_n && !preset_enable_n) |=> (count_reg == 4'h0)
  ) else $error("sync clear did not override preset");

  a_preset_load: assert property (
    @(posedge clock) disable iff (rst || !async_clear_n)
    (sync_clear_n && !preset_enable_n)
    |=> (count_reg == $past(preset_value_in))
  ) else $error("preset value not loaded");

  a_hold_value: assert property (
    @(posedge clock) disable iff (rst || !async_clear_n)
    (sync_clear_n && preset_enable_n
     && (count_enable_parallel_n || count_enable_trickle_n))
    |=> $stable(count_reg)
  ) else $error("count changed while disabled");

  a_count_step: assert property (
    @(posedge clock) disable iff (rst || !async_clear_n)
    (!decade && mode == udbc_pkg::MODE_COUNT)
    |=> (count_reg == ($past(count_up) ? $past(count_reg) + 4'h1
                                        : $past(count_reg) - 4'h1))
  ) else $error("count stepped the wrong way");

  a_tc_decode: assert property (
    @(posedge clock) disable iff (rst)
    (!count_enable_trickle_n && count_up && decade
     && count_value_out == 4'h9) |-> !terminal_count_n
  ) else $error("terminal count missing at nine");

  a_tc_idle: assert property (
    @(posedge clock) disable iff (rst)
    count_enable_trickle_n |-> terminal_count_n
  ) else $error("terminal count low with trickle high");

  a_carry_low: assert property (
    @(posedge clock) disable iff (rst || !async_clear_n)
    (sync_clear_n && preset_enable_n && count_en && at_limit)
    |-> !gated_carry_n
  ) else $error("carry not low in clock low phase");

  // Sampled just before the falling edge, so the clock is still high
  a_carry_high: assert property (
    @(negedge clock) disable iff (rst)
    gated_carry_n
  ) else $error("carry low in clock high phase");

  a_out_enable: assert property (
    @(posedge clock) disable iff (rst)
    count_value_oe == !output_enable_n && count_value_out == count_reg
  ) else $error("output enable or data wrong");

  a_decade_recover: assert property (
    @(posedge clock) disable iff (rst || !async_clear_n)
    (decade && mode == udbc_pkg::MODE_COUNT && count_reg > 4'h9)
    |=> (count_reg <= 4'h9)
  ) else $error("decade count stuck out of range");

  a_irq_level: assert property (
    @(posedge clock) disable iff (rst)
    ($rose(status[0]) && mask_reg[0]) |-> irq
  ) else $error("interrupt not raised");

endmodule : udbc_counter

// *** core/udbc_step.sv ***
// Next count value and limit decode for one counting step.
// Assumes a 4-bit state; pure combinational logic.
`timescale 1ns/1ps
module udbc_step (
  input  wire logic [3:0] state,     // Present count
  input  wire logic       decade,    // 1 selects modulo-10
  input  wire logic       up,        // 1 counts up
  output logic      [3:0] next_val,  // Value after one step
  output logic            at_limit   // Max when up, zero when down
);

  logic [3:0] top;

  always_comb begin
    top = decade ? udbc_pkg::DEC_MAX : udbc_pkg::BIN_MAX;
    at_limit = up ? (state == top) : (state == udbc_pkg::CNT_ZERO);
    next_val = state;
    if (up) begin
      // States above nine in decade mode fall back to zero
      if (state >= top) begin
        next_val = udbc_pkg::CNT_ZERO;
      end else begin
        next_val = state + 4'h1;
      end
    end else begin
      if (state == udbc_pkg::CNT_ZERO || state > top) begin
        next_val = top;
      end else begin
        next_val = state - 4'h1;
      end
    end
  end

endmodule : udbc_step

// *** core/udbc_sticky.sv ***
// Sticky event bits; a set in the cycle of a clear wins.
// Assumes set pulses and clear masks on the same clock.
`timescale 1ns/1ps
module udbc_sticky #(
  parameter int W = 4
) (
  input  wire logic         clock,  // System clock
  input  wire logic         rst,    // Synchronous reset
  input  wire logic [W-1:0] set,    // Event pulses
  input  wire logic [W-1:0] clr,    // Bits to clear
  output logic      [W-1:0] q       // Sticky state
);

  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    q_next = set | (q_reg & ~clr);
    if (rst) begin
      q_next = '0;
    end
  end

  always_ff @(posedge clock) begin
    q_reg <= q_next;
  end

  assign q = q_reg;

endmodule : udbc_sticky

// *** pkg/udbc_pkg.sv ***
// Constants shared by the up/down decade or binary counter block.
// Assumes a 32-bit APB slave with byte addresses in paddr.
package udbc_pkg;

  localparam int CNT_W = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [3:0] DEC_MAX = 4'h9;
  localparam logic [3:0] BIN_MAX = 4'hf;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] CNT_OFS = 8'h0c;

  localparam int CTRL_DECADE_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;

  localparam int EVT_W = 4;
  localparam int EVT_UPWRAP = 0;
  localparam int EVT_DNWRAP = 1;
  localparam int EVT_LOAD = 2;
  localparam int EVT_SCLR = 3;
  localparam logic [3:0] MASK_RST = 4'h0;

  localparam int CNT_LIMIT_BIT = 4;
  localparam int CNT_DIR_BIT = 5;
  localparam int CNT_OE_BIT = 6;

  typedef enum logic [1:0] {
    MODE_SCLR,
    MODE_LOAD,
    MODE_COUNT,
    MODE_HOLD
  } udbc_mode_t;

endpackage : udbc_pkg

// *** tb/udbc_counter_tb_top.sv ***
// Self-checking bench for the up/down counter and its register view.
// Assumes the design package and the cascade stage model are compiled first.
`timescale 1ns/1ps
module udbc_counter_tb_top;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, oe, tcn, ccn, irq;
  logic        acn = 1'b1, scn = 1'b1, pen = 1'b1, cepn = 1'b1, cetn = 1'b1;
  logic        up = 1'b1, oen = 1'b0;
  logic [3:0]  pv = 4'h0, q, sq, np;
  int          fails = 0, n_checks = 0;

  always #50 clock = ~clock;

  udbc_counter DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .async_clear_n(acn), .sync_clear_n(scn),
    .preset_enable_n(pen), .count_enable_parallel_n(cepn),
    .count_enable_trickle_n(cetn), .count_up(up), .output_enable_n(oen),
    .preset_value_in(pv), .count_value_out(q), .count_value_oe(oe),
    .terminal_count_n(tcn), .gated_carry_n(ccn), .irq(irq));

  udbc_next_stage peer (.clock(clock), .rst(rst), .limit_n(tcn), .par_en_n(cepn),
    .carry_n(ccn), .stage_q(sq), .pulses(np));

  task conclude;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // Holds the request until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      fails++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // c is {sync clear, preset, parallel, trickle}, all active low
  task go(input logic [3:0] c, input logic u, input logic [3:0] p,
          input logic etc, input logic ecc, input logic [3:0] eq);
    @(posedge clock);
    {scn, pen, cepn, cetn} <= c;
    up <= u;
    pv <= p;
    #60;
    chk("limit", etc, tcn);
    chk("carry", ecc, ccn);
    @(posedge clock);
    {scn, pen, cepn} <= 3'b111;
    #1;
    chk("count", eq, q);
  endtask : go

  task t_regs;
    chk("reset count", 4'h0, q);
    apb(1'b0, udbc_pkg::CTRL_OFS, 32'h0);
    chk("ctrl", udbc_pkg::CTRL_RST, rd);
    chk("slverr clear", 1'b0, err);
    apb(1'b0, udbc_pkg::MASK_OFS, 32'h0);
    chk("mask", 32'h0, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 1'b1, err);
    chk("unmapped", 32'h0, rd);
    apb(1'b1, udbc_pkg::MASK_OFS, 32'h1);
    apb(1'b0, udbc_pkg::MASK_OFS, 32'h0);
    chk("mask written", 32'h1, rd);
    $display("test regs done");
  endtask : t_regs

  task t_decade;
    go(4'hb, 1'b1, 4'h8, 1'b1, 1'b1, 4'h8);
    go(4'hc, 1'b1, 4'h0, 1'b1, 1'b1, 4'h9);
    go(4'hc, 1'b1, 4'h0, 1'b0, 1'b0, 4'h0);
    chk("irq set", 1'b1, irq);
    apb(1'b0, udbc_pkg::STAT_OFS, 32'h0);
    chk("stat", 32'h5, rd);
    #1;
    chk("irq clear", 1'b0, irq);
    go(4'hb, 1'b1, 4'hc, 1'b1, 1'b1, 4'hc);
    go(4'hc, 1'b1, 4'h0, 1'b1, 1'b1, 4'h0);
    go(4'hb, 1'b0, 4'hc, 1'b1, 1'b1, 4'hc);
    go(4'hc, 1'b0, 4'h0, 1'b1, 1'b1, 4'h9);
    $display("test decade done");
  endtask : t_decade

  task t_binary;
    apb(1'b1, udbc_pkg::CTRL_OFS, 32'h0);
    apb(1'b0, udbc_pkg::STAT_OFS, 32'h0);
    go(4'hb, 1'b0, 4'h1, 1'b1, 1'b1, 4'h1);
    go(4'hc, 1'b0, 4'h0, 1'b1, 1'b1, 4'h0);
    go(4'hc, 1'b0, 4'h0, 1'b0, 1'b0, 4'hf);
    go(4'hc, 1'b1, 4'h0, 1'b0, 1'b0, 4'h0);
    apb(1'b0, udbc_pkg::STAT_OFS, 32'h0);
    chk("stat", 32'h7, rd);
    $display("test binary done");
  endtask : t_binary

  task t_prio;
    go(4'h0, 1'b1, 4'h5, 1'b1, 1'b1, 4'h0);
    go(4'h8, 1'b1, 4'h5, 1'b1, 1'b1, 4'h5);
    go(4'he, 1'b1, 4'h0, 1'b1, 1'b1, 4'h5);
    go(4'hd, 1'b1, 4'h0, 1'b1, 1'b1, 4'h5);
    apb(1'b0, udbc_pkg::STAT_OFS, 32'h0);
    chk("stat", 32'hc, rd);
    apb(1'b0, udbc_pkg::CNT_OFS, 32'h0);
    chk("count reg", 32'h65, rd);
    $display("test priority done");
  endtask : t_prio

  task t_async;
    @(posedge clock);
    acn <= 1'b0;
    oen <= 1'b1;
    #1;
    chk("async count", 4'h0, q);
    chk("oe off", 1'b0, oe);
    @(posedge clock);
    acn <= 1'b1;
    go(4'hc, 1'b1, 4'h0, 1'b1, 1'b1, 4'h1);
    @(posedge clock);
    oen <= 1'b0;
    #1;
    chk("oe on", 1'b1, oe);
    $display("test async done");
  endtask : t_async

  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_decade();
    t_binary();
    t_prio();
    t_async();
    chk("next stage", 4'h3, sq);
    chk("carry pulses", 4'h3, np);
    conclude();
  end
endmodule : udbc_counter_tb_top

// *** tb/udbc_next_stage.sv ***
// Second counter stage cascaded behind the block in lookahead form.
// Assumes it shares clock and rst with the counter under test.
`timescale 1ns/1ps
module udbc_next_stage (
  input  wire logic       clock,    // Shared clock
  input  wire logic       rst,      // Reset; sync for stage_q, async for pulses
  input  wire logic       limit_n,  // First stage terminal count
  input  wire logic       par_en_n, // Shared parallel enable
  input  wire logic       carry_n,  // First stage clocked carry
  output logic      [3:0] stage_q,  // This stage's count
  output logic      [3:0] pulses    // Carry pulses seen
);
  always_ff @(posedge clock) begin
    if (rst) begin
      stage_q <= 4'h0;
    end else if (!limit_n && !par_en_n) begin
      stage_q <= stage_q + 4'h1;
    end
  end

  // Carry serves as a clock; the decode output may glitch
  always_ff @(posedge carry_n or posedge rst) begin
    if (rst) begin
      pulses <= 4'h0;
    end else begin
      pulses <= pulses + 4'h1;
    end
  end
endmodule : udbc_next_stage
